// ### irq_pulse_and_multipin_mux.sv
`timescale 1ns/1ps
module irq_pulse_and_multipin_mux
   import irq_mux_pkg::*;
#(
   parameter int PULSE_CYC = PULSE_CYCLES,
   parameter int GAP_CYC   = GAP_CYCLES
) (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // Register port
   input  wire logic [7:0] i_reg_addr,
   input  wire logic [7:0] i_reg_wdata,
   input  wire logic       i_reg_wr,
   input  wire logic       i_reg_rd,
   output logic      [7:0] o_reg_rdata,
   // Event sources, one-cycle pulses
   input  wire logic       i_ev_short_left,
   input  wire logic       i_ev_short_right,
   input  wire logic       i_ev_button,
   input  wire logic       i_ev_headset,
   input  wire logic       i_ev_drc_left,
   input  wire logic       i_ev_drc_right,
   input  wire logic       i_ev_overflow,
   // Clock sources for the pin
   input  wire logic       i_internal_clock_out,
   input  wire logic       i_sec_bclk,
   input  wire logic       i_sec_wclk,
   // Interrupt outputs
   output logic            o_first_irq_output,
   output logic            o_second_irq_output,
   // Multifunction pin
   input  wire logic       i_multifunction_pin,
   output logic            o_multifunction_pin,
   output logic            o_multifunction_pin_oe,
   output logic            o_multifunction_pin_ibuf_en,
   output logic            o_mfp_sec_input,
   output logic            o_mfp_sec_input_valid
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [7:0] irq_one_ctrl;
   logic [7:0] next_irq_one_ctrl;
   logic [7:0] irq_two_ctrl;
   logic [7:0] next_irq_two_ctrl;
   logic [1:0] mp_reserved;
   logic [1:0] next_mp_reserved;
   mp_mode_t   mp_mode;
   mp_mode_t   next_mp_mode;
   logic       mp_out_val;
   logic       next_mp_out_val;
   logic [7:0] sticky;
   logic [7:0] next_sticky;
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic       pin_meta;
   logic       pin_sync;
   logic       pin_out;
   logic       next_pin_out;
   logic       pin_oe;
   logic       next_pin_oe;
   logic       ibuf_en;
   logic       next_ibuf_en;
   logic       sec_in;
   logic       next_sec_in;
   logic       sec_valid;
   logic       next_sec_valid;
   logic [7:0] event_vec;
   logic       flags_read;

   pulse_if pulse_one ();
   pulse_if pulse_two ();

   // Uniform enable decode shared by both interrupt outputs
   function automatic logic irq_fire(input logic [7:0] ctrl, input logic [7:0] ev,
                                     input logic ovf);
      irq_fire = (ctrl[BIT_EN_HEADSET] & ev[4])
               | (ctrl[BIT_EN_BUTTON]  & ev[5])
               | (ctrl[BIT_EN_DRC]     & (ev[3] | ev[2]))
               | (ctrl[BIT_EN_SHORT]   & (ev[7] | ev[6]))
               | (ctrl[BIT_EN_OVERFLOW] & ovf);
   endfunction

   function automatic logic [7:0] pin_reg(input logic [1:0] rsv, input mp_mode_t m,
                                          input logic din, input logic dout);
      pin_reg = {rsv, m, din, dout};
   endfunction

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   assign event_vec  = {i_ev_short_left, i_ev_short_right, i_ev_button, i_ev_headset,
                        i_ev_drc_left, i_ev_drc_right, 2'b00};
   // Any flag read also ends both pulse trains
   assign flags_read = i_reg_rd && (i_reg_addr == ADDR_STICKY_FLAGS);

   always_comb begin
      next_irq_one_ctrl = irq_one_ctrl;
      next_irq_two_ctrl = irq_two_ctrl;
      next_mp_reserved  = mp_reserved;
      next_mp_mode      = mp_mode;
      next_mp_out_val   = mp_out_val;
      next_rdata        = rdata;
      // Set beats the read-clear so a coincident event is kept
      next_sticky = (flags_read ? 8'h00 : sticky) | event_vec;
      if (i_reg_wr) begin
         case (i_reg_addr)
            ADDR_IRQ_ONE_CONTROL: next_irq_one_ctrl = i_reg_wdata;
            ADDR_IRQ_TWO_CONTROL: next_irq_two_ctrl = i_reg_wdata;
            ADDR_MULTIPIN_CTRL: begin
               next_mp_reserved = i_reg_wdata[7:6];
               next_mp_mode     = mp_mode_t'(i_reg_wdata[5:2]);
               next_mp_out_val  = i_reg_wdata[BIT_PIN_OUT];
            end
            default: begin
            end
         endcase
      end
      if (i_reg_rd) begin
         case (i_reg_addr)
            ADDR_STICKY_FLAGS:    next_rdata = sticky;
            ADDR_IRQ_ONE_CONTROL: next_rdata = irq_one_ctrl;
            ADDR_IRQ_TWO_CONTROL: next_rdata = irq_two_ctrl;
            ADDR_MULTIPIN_CTRL:   next_rdata = pin_reg(mp_reserved, mp_mode,
                                                       pin_sync & ibuf_en,
                                                       mp_out_val);
            default:              next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         irq_one_ctrl <= RST_IRQ_CONTROL;
         irq_two_ctrl <= RST_IRQ_CONTROL;
         mp_reserved  <= RST_MP_RESERVED;
         mp_mode      <= MP_DISABLED;
         mp_out_val   <= 1'b0;
         sticky       <= RST_STICKY_FLAGS;
         rdata        <= RST_READ_DATA;
      end else begin
         irq_one_ctrl <= next_irq_one_ctrl;
         irq_two_ctrl <= next_irq_two_ctrl;
         mp_reserved  <= next_mp_reserved;
         mp_mode      <= next_mp_mode;
         mp_out_val   <= next_mp_out_val;
         sticky       <= next_sticky;
         rdata        <= next_rdata;
      end
   end

   assign o_reg_rdata = rdata;

   // ----------------------------------------
   // Interrupt pulse generators
   // ----------------------------------------
   assign pulse_one.trigger     = irq_fire(irq_one_ctrl, event_vec, i_ev_overflow);
   assign pulse_one.repeat_mode = irq_one_ctrl[BIT_REPEAT];
   assign pulse_one.stop        = flags_read;
   assign pulse_two.trigger     = irq_fire(irq_two_ctrl, event_vec, i_ev_overflow);
   assign pulse_two.repeat_mode = irq_two_ctrl[BIT_REPEAT];
   assign pulse_two.stop        = flags_read;

   irq_pulse_gen #(
      .HIGH_CYC (PULSE_CYC),
      .LOW_CYC  (GAP_CYC)
   ) u_pulse_one (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .pg    (pulse_one.gen)
   );

   irq_pulse_gen #(
      .HIGH_CYC (PULSE_CYC),
      .LOW_CYC  (GAP_CYC)
   ) u_pulse_two (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .pg    (pulse_two.gen)
   );

   // Already registered inside the generators
   assign o_first_irq_output  = pulse_one.pulse;
   assign o_second_irq_output = pulse_two.pulse;

   // ----------------------------------------
   // Multifunction pin
   // ----------------------------------------
   // Pin is asynchronous; two flops before any reader
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
      end else begin
         pin_meta <= i_multifunction_pin;
         pin_sync <= pin_meta;
      end
   end

   // One flop of latency on every pin output, clocks included
   always_comb begin
      next_pin_out   = 1'b0;
      next_pin_oe    = 1'b0;
      next_ibuf_en   = 1'b0;
      next_sec_in    = 1'b0;
      next_sec_valid = 1'b0;
      // Code seven and codes ten to fifteen fall into the default branch
      case (mp_mode)
         MP_DISABLED: begin
            next_pin_oe  = 1'b0;
            next_ibuf_en = 1'b0;
         end
         MP_INPUT: begin
            next_ibuf_en   = 1'b1;
            next_sec_in    = pin_sync;
            next_sec_valid = 1'b1;
         end
         MP_PLAIN_IN: begin
            next_ibuf_en = 1'b1;
         end
         MP_PLAIN_OUT: begin
            next_pin_oe  = 1'b1;
            next_pin_out = mp_out_val;
            next_ibuf_en = 1'b1;
         end
         MP_CLOCK_OUT: begin
            next_pin_oe  = 1'b1;
            next_pin_out = i_internal_clock_out;
            next_ibuf_en = 1'b1;
         end
         MP_IRQ_ONE: begin
            next_pin_oe  = 1'b1;
            next_pin_out = pulse_one.pulse;
            next_ibuf_en = 1'b1;
         end
         MP_IRQ_TWO: begin
            next_pin_oe  = 1'b1;
            next_pin_out = pulse_two.pulse;
            next_ibuf_en = 1'b1;
         end
         MP_SEC_BCLK: begin
            next_pin_oe  = 1'b1;
            next_pin_out = i_sec_bclk;
            next_ibuf_en = 1'b1;
         end
         MP_SEC_WCLK: begin
            next_pin_oe  = 1'b1;
            next_pin_out = i_sec_wclk;
            next_ibuf_en = 1'b1;
         end
         default: begin
            // Reserved code behaves as disabled
            next_pin_oe  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pin_out   <= 1'b0;
         pin_oe    <= 1'b0;
         ibuf_en   <= 1'b0;
         sec_in    <= 1'b0;
         sec_valid <= 1'b0;
      end else begin
         pin_out   <= next_pin_out;
         pin_oe    <= next_pin_oe;
         ibuf_en   <= next_ibuf_en;
         sec_in    <= next_sec_in;
         sec_valid <= next_sec_valid;
      end
   end

   assign o_multifunction_pin         = pin_out;
   assign o_multifunction_pin_oe      = pin_oe;
   assign o_multifunction_pin_ibuf_en = ibuf_en;
   assign o_mfp_sec_input             = sec_in;
   assign o_mfp_sec_input_valid       = sec_valid;

endmodule

// ### irq_mux_pkg.sv
package irq_mux_pkg;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_STICKY_FLAGS    = 8'h2C;
   localparam logic [7:0] ADDR_IRQ_ONE_CONTROL = 8'h30;
   localparam logic [7:0] ADDR_IRQ_TWO_CONTROL = 8'h31;
   localparam logic [7:0] ADDR_RESERVED_A      = 8'h32;
   localparam logic [7:0] ADDR_MULTIPIN_CTRL   = 8'h33;
   localparam logic [7:0] ADDR_RESERVED_B      = 8'h34;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int BIT_EN_HEADSET  = 7;
   localparam int BIT_EN_BUTTON   = 6;
   localparam int BIT_EN_DRC      = 5;
   localparam int BIT_EN_SHORT    = 3;
   localparam int BIT_EN_OVERFLOW = 2;
   localparam int BIT_REPEAT      = 0;
   localparam int BIT_MODE_LSB    = 2;
   localparam int BIT_PIN_IN      = 1;
   localparam int BIT_PIN_OUT     = 0;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] RST_IRQ_CONTROL  = 8'h00;
   localparam logic [1:0] RST_MP_RESERVED  = 2'h0;
   localparam logic [7:0] RST_STICKY_FLAGS = 8'h00;
   localparam logic [7:0] RST_READ_DATA    = 8'h00;

   // ----------------------------------------
   // Multifunction pin modes
   // ----------------------------------------
   typedef enum logic [3:0] {
      MP_DISABLED   = 4'h0,
      MP_INPUT      = 4'h1,
      MP_PLAIN_IN   = 4'h2,
      MP_PLAIN_OUT  = 4'h3,
      MP_CLOCK_OUT  = 4'h4,
      MP_IRQ_ONE    = 4'h5,
      MP_IRQ_TWO    = 4'h6,
      MP_RESERVED   = 4'h7,
      MP_SEC_BCLK   = 4'h8,
      MP_SEC_WCLK   = 4'h9
   } mp_mode_t;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ       = 20_000_000;
   localparam int PULSE_MS     = 2;
   localparam int PERIOD_MS    = 4;
   localparam int PULSE_CYCLES = (CLK_HZ / 1000) * PULSE_MS;
   localparam int GAP_CYCLES   = (CLK_HZ / 1000) * (PERIOD_MS - PULSE_MS);
   localparam int CNT_W        = 24;

endpackage

// ### pulse_if.sv
`timescale 1ns/1ps
interface pulse_if;
   logic trigger;
   logic repeat_mode;
   logic stop;
   logic pulse;

   modport gen (
      input  trigger,
      input  repeat_mode,
      input  stop,
      output pulse
   );
   modport ctl (
      output trigger,
      output repeat_mode,
      output stop,
      input  pulse
   );
endinterface

// ### irq_pulse_gen.sv
`timescale 1ns/1ps
module irq_pulse_gen
   import irq_mux_pkg::*;
#(
   parameter int HIGH_CYC = PULSE_CYCLES,
   parameter int LOW_CYC  = GAP_CYCLES
) (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst,
   // Control
   pulse_if.gen      pg
);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_HIGH = 2'b01,
      ST_LOW  = 2'b10
   } pg_state_t;

   localparam logic [CNT_W-1:0] HIGH_LAST = CNT_W'(HIGH_CYC - 1);
   localparam logic [CNT_W-1:0] LOW_LAST  = CNT_W'(LOW_CYC - 1);

   pg_state_t        state;
   pg_state_t        next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic             stopped;
   logic             next_stopped;
   logic             pulse;
   logic             next_pulse;

   // ----------------------------------------
   // Pulse sequencer
   // ----------------------------------------
   always_comb begin
      next_state   = state;
      next_cnt     = cnt + CNT_W'(1);
      // A recurring event re-arms the train even after a flag read
      next_stopped = pg.trigger ? 1'b0 : (stopped | pg.stop);
      case (state)
         ST_IDLE: begin
            next_cnt = '0;
            if (pg.trigger) begin
               next_state = ST_HIGH;
            end
         end
         ST_HIGH: begin
            if (cnt == HIGH_LAST) begin
               next_cnt = '0;
               if (pg.repeat_mode && !next_stopped) begin
                  next_state = ST_LOW;
               end else begin
                  next_state = ST_IDLE;
               end
            end
         end
         ST_LOW: begin
            if (next_stopped) begin
               next_state = ST_IDLE;
               next_cnt   = '0;
            end else if (cnt == LOW_LAST) begin
               next_state = ST_HIGH;
               next_cnt   = '0;
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_cnt   = '0;
         end
      endcase
      next_pulse = (next_state == ST_HIGH);
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state   <= ST_IDLE;
         cnt     <= '0;
         stopped <= 1'b0;
         pulse   <= 1'b0;
      end else begin
         state   <= next_state;
         cnt     <= next_cnt;
         stopped <= next_stopped;
         pulse   <= next_pulse;
      end
   end

   assign pg.pulse = pulse;

endmodule

// ### irq_mux_assertions.sv
`timescale 1ns/1ps
module irq_mux_checker
   import irq_mux_pkg::*;
#(
   parameter int PULSE_CYC = PULSE_CYCLES
) (
   // Clock and reset
   input wire logic       i_clk,
   input wire logic       i_rst,
   // Register port
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic       i_reg_wr,
   input wire logic       i_reg_rd,
   input wire logic [7:0] o_reg_rdata,
   // Events and outputs
   input wire logic       i_ev_button,
   input wire logic       i_ev_headset,
   input wire logic       i_internal_clock_out,
   input wire logic       o_first_irq_output,
   input wire logic       o_second_irq_output,
   input wire logic       o_multifunction_pin,
   input wire logic       o_multifunction_pin_oe,
   input wire logic       o_multifunction_pin_ibuf_en
);
   // ----------------------------------------
   // Shadow state
   // ----------------------------------------
   logic [7:0] k1;
   logic [7:0] k2;
   logic [7:0] mp;
   logic [7:0] md;
   int         c1;
   int         c2;
   logic [3:0] m;
   assign m = md[5:2];
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // Mode copy lags one cycle, matching the pin's registered answer
   always_ff @(posedge i_clk) begin
      md <= mp;
      c1 <= o_first_irq_output ? c1 + 1 : 0;
      c2 <= o_second_irq_output ? c2 + 1 : 0;
      if (i_rst) begin
         k1 <= 8'h00;
         k2 <= 8'h00;
         mp <= 8'h00;
      end else if (i_reg_wr) begin
         if (i_reg_addr == ADDR_IRQ_ONE_CONTROL) k1 <= i_reg_wdata;
         if (i_reg_addr == ADDR_IRQ_TWO_CONTROL) k2 <= i_reg_wdata;
         if (i_reg_addr == ADDR_MULTIPIN_CTRL) mp <= i_reg_wdata;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   AST_IRQ1_WIDTH: assert property ($fell(o_first_irq_output) |-> c1 == PULSE_CYC)
      else $error("first irq pulse width wrong");
   AST_IRQ2_WIDTH: assert property ($fell(o_second_irq_output) |-> c2 == PULSE_CYC)
      else $error("second irq pulse width wrong");
   AST_IRQ_MAX: assert property ((o_first_irq_output || o_second_irq_output)
      |-> c1 < PULSE_CYC && c2 < PULSE_CYC) else $error("irq pulse too long");
   AST_IRQ1_START: assert property (!k1[0] && !o_first_irq_output && k1[6] && i_ev_button
      |=> o_first_irq_output) else $error("first irq did not start");
   AST_IRQ2_START: assert property (!k2[0] && !o_second_irq_output && k2[7] && i_ev_headset
      |=> o_second_irq_output) else $error("second irq did not start");
   AST_RD_ZERO: assert property (i_reg_rd && (i_reg_addr > 8'h34 || i_reg_addr < 8'h2C)
      |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
   AST_MP_OFF: assert property ((m == 4'h0 || m == 4'h7 || m > 4'h9)
      |-> !o_multifunction_pin_oe && !o_multifunction_pin_ibuf_en) else $error("pin not off");
   AST_MP_OUT: assert property (m == 4'h3
      |-> o_multifunction_pin_oe && o_multifunction_pin == md[0]) else $error("pin level wrong");
   AST_MP_CLK: assert property (m == 4'h4
      |-> o_multifunction_pin == $past(i_internal_clock_out)) else $error("clock out wrong");
endmodule

bind irq_pulse_and_multipin_mux irq_mux_checker #(.PULSE_CYC(PULSE_CYC)) chk_i (.*);

// ### irq_host_model.sv
`timescale 1ns/1ps
module irq_host_model (
   // Clock
   input  wire logic i_clk,
   // Pin and interrupt lines
   input  wire logic i_oe,
   input  wire logic i_out,
   input  wire logic i_drv,
   input  wire logic i_irq1,
   input  wire logic i_irq2,
   // Observations
   output logic      o_wire,
   output int        o_r1 = 0,
   output int        o_r2 = 0,
   output int        o_w1 = 0,
   output int        o_w2 = 0
);
   logic p1 = 1'b0;
   logic p2 = 1'b0;
   int   h1 = 0;
   int   h2 = 0;
   // Host drives the pin only while the device has let go
   assign o_wire = i_oe ? i_out : i_drv;
   always @(posedge i_clk) begin
      p1 <= i_irq1;
      p2 <= i_irq2;
      h1 <= i_irq1 ? h1 + 1 : 0;
      h2 <= i_irq2 ? h2 + 1 : 0;
      if (i_irq1 && !p1) o_r1 <= o_r1 + 1;
      if (i_irq2 && !p2) o_r2 <= o_r2 + 1;
      if (!i_irq1 && p1) o_w1 <= h1;
      if (!i_irq2 && p2) o_w2 <= h2;
   end
endmodule

// ### irq_pulse_and_multipin_mux_tb.sv
`timescale 1ns/1ps
module irq_pulse_and_multipin_mux_tb;
   import irq_mux_pkg::*;
   localparam int P = 8;
   logic       clk = 0;
   logic       rst = 1;
   logic [7:0] addr = 0;
   logic [7:0] wdata = 0;
   logic       wr = 0;
   logic       rd = 0;
   logic [6:0] ev = 0;
   logic       drv = 1;
   logic [2:0] cks = 3'b101;
   logic [7:0] rdata;
   logic       irq1, irq2, pin, oe, ibuf, sec, secv, wire_lvl;
   int         err_total = 0;
   int         tests_run = 0;
   int         r1, r2, w1, w2, b1, b2, j;
   int         src[5] = '{6, 5, 4, 1, 0};
   logic [7:0] en[5] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h04};
   logic [7:0] flg[5] = '{8'h10, 8'h20, 8'h08, 8'h40, 8'h00};
   logic [15:0] oe_t = 16'h0378;
   logic [15:0] ib_t = 16'h037E;
   logic [15:0] out_t = 16'h0218;
   logic [7:0] adr_t[7] = '{8'h2C, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h40};

   irq_pulse_and_multipin_mux #(.PULSE_CYC(P), .GAP_CYC(P)) uut (
      .i_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
      .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
      .i_ev_headset(ev[6]), .i_ev_button(ev[5]), .i_ev_drc_left(ev[4]),
      .i_ev_drc_right(ev[3]), .i_ev_short_left(ev[2]), .i_ev_short_right(ev[1]),
      .i_ev_overflow(ev[0]), .i_internal_clock_out(cks[0]), .i_sec_bclk(cks[1]),
      .i_sec_wclk(cks[2]), .o_first_irq_output(irq1), .o_second_irq_output(irq2),
      .i_multifunction_pin(wire_lvl), .o_multifunction_pin(pin),
      .o_multifunction_pin_oe(oe), .o_multifunction_pin_ibuf_en(ibuf),
      .o_mfp_sec_input(sec), .o_mfp_sec_input_valid(secv));
   irq_host_model host (
      .i_clk(clk), .i_oe(oe), .i_out(pin), .i_drv(drv), .i_irq1(irq1),
      .i_irq2(irq2), .o_wire(wire_lvl), .o_r1(r1), .o_r2(r2), .o_w1(w1), .o_w2(w2));

   initial begin
      forever #25 clk = ~clk;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] s, input logic [7:0] e, input string n);
      tests_run++;
      if (s !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wrr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a; wdata = d; wr = 1;
      @(negedge clk);
      wr = 0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string n);
      @(negedge clk);
      addr = a; rd = 1;
      @(negedge clk);
      rd = 0;
      chk(rdata, e, n);
   endtask
   task automatic fire(input int i);
      @(negedge clk);
      ev[i] = 1;
      @(negedge clk);
      ev = 0;
   endtask
   task automatic do_reset;
      @(negedge clk);
      rst = 1;
      cyc(4);
      rst = 0;
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Generous bound, real run is well under a thousand cycles
   initial begin
      #(20000 * 50);
      err_total++;
      conclude;
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      do_reset;
      wrr(8'h30, 8'hA5);
      rdc(8'h30, 8'hA5, "ctl one rw");
      wrr(8'h31, 8'h5A);
      rdc(8'h31, 8'h5A, "ctl two rw");
      wrr(8'h32, 8'hFF);
      wrr(8'h2C, 8'hFF);
      rdc(8'h32, 8'h00, "reserved ignores write");
      rdc(8'h2C, 8'h00, "flags ignore write");
      do_reset;
      foreach (adr_t[i]) rdc(adr_t[i], 8'h00, "reset value");
      $display("test registers done");
      for (int s = 0; s < 2; s++) begin
         for (int i = 0; i < 5; i++) begin
            j = (i + 1) % 5;
            wrr(s ? 8'h31 : 8'h30, en[i]);
            b1 = r1; b2 = r2;
            fire(src[j]);
            cyc(P + 4);
            fire(src[i]);
            cyc(P + 4);
            chk(8'(r1 - b1), s ? 8'd0 : 8'd1, "first irq count");
            chk(8'(r2 - b2), s ? 8'd1 : 8'd0, "second irq count");
            chk(8'(s ? w2 : w1), 8'(P), "pulse width");
            rdc(8'h2C, flg[i] | flg[j], "sticky flags");
            rdc(8'h2C, 8'h00, "sticky cleared");
            wrr(s ? 8'h31 : 8'h30, 8'h00);
         end
      end
      $display("test sources done");
      wrr(8'h30, 8'h41);
      wrr(8'h31, 8'h41);
      b1 = r1; b2 = r2;
      fire(5);
      cyc(40);
      chk(8'(r1 - b1), 8'd3, "first train");
      chk(8'(r2 - b2), 8'd3, "second train");
      rdc(8'h2C, 8'h20, "train flags");
      b1 = r1; b2 = r2;
      cyc(40);
      chk(8'(r1 - b1), 8'd0, "first stopped");
      chk(8'(r2 - b2), 8'd0, "second stopped");
      wrr(8'h30, 8'h00);
      wrr(8'h31, 8'h00);
      @(negedge clk);
      addr = 8'h2C; rd = 1; ev[5] = 1;
      @(negedge clk);
      rd = 0; ev = 0;
      chk(rdata, 8'h00, "read before set");
      rdc(8'h2C, 8'h20, "set beats clear");
      $display("test trains done");
      for (int m = 0; m < 16; m++) begin
         wrr(8'h33, {2'b00, 4'(m), 2'b01});
         cyc(3);
         chk(8'(oe), 8'(oe_t[m]), "pin drive");
         chk(8'(ibuf), 8'(ib_t[m]), "input buffer");
         chk(8'(secv), 8'(m == 1), "sec valid");
         chk(8'(sec), 8'(m == 1), "sec level");
         if (oe_t[m]) chk(8'(pin), 8'(out_t[m]), "pin level");
         rdc(8'h33, {2'b00, 4'(m), ib_t[m] & (oe_t[m] ? out_t[m] : 1'b1), 1'b1},
             "pin control");
         if (m == 4 || m == 8 || m == 9) begin
            j = (m == 4) ? 0 : m - 7;
            cks[j] = ~cks[j];
            cyc(2);
            chk(8'(pin), 8'(!out_t[m]), "pin follows source");
            cks[j] = ~cks[j];
         end
         if (m == 5 || m == 6) begin
            wrr(m == 5 ? 8'h30 : 8'h31, 8'h40);
            fire(5);
            cyc(2);
            chk(8'(pin), 8'h01, "pin carries irq");
            cyc(P);
            rdc(8'h2C, 8'h20, "routed flags");
            wrr(m == 5 ? 8'h30 : 8'h31, 8'h00);
         end
      end
      wrr(8'h33, 8'h0C);
      cyc(3);
      chk(8'(pin), 8'h00, "plain out low");
      $display("test pin done");
      conclude;
   end
endmodule
